// ---- rtl/csl_top.sv ----
// Camera status and network LED encoder with APB register access
// Contract
// - Status LED shows the highest-priority active condition only.
// - Red steady uninitialized, slow on init failure, fast when too hot.
// - Slow blue while waiting for an IP address.
// - Fast blue while Ethernet link is down.
// - Steady blue with IP and no application; steady green when connected.
// - Slow green triggered acquisition; fast green free-running acquisition.
// - Connection LED green at 100 Mbit/s, orange at 1000 Mbit/s.
// - Activity LED dark without traffic, blinking yellow with traffic.
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
module csl_top (
	input wire logic CLOCK_IN,
	input wire logic RSTN_IN,
	input wire logic [csl_pkg::N_STAT-1:0] STATUS_IN,
	input wire logic LINK_100_IN,
	input wire logic LINK_1000_IN,
	input wire logic TRAFFIC_IN,
	input wire logic [csl_pkg::ADDR_W-1:0] PADDR_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	output csl_pkg::csl_rgb_t STATUS_LED_OUT,
	output csl_pkg::csl_net_t NET_LED_OUT,
	output logic IRQ_OUT
);
	csl_pkg::csl_apb_req_t req;
	logic [31:0] slow_div;
	logic [31:0] fast_div;
	logic [csl_pkg::N_STAT-1:0] irq_stat;
	logic [csl_pkg::N_STAT-1:0] irq_mask;
	logic [csl_pkg::N_STAT-1:0] stat_prev;
	logic [csl_pkg::N_STAT-1:0] stat_rise;
	logic slow_wave;
	logic fast_wave;
	logic act_wave;
	logic led_force;
	logic wr_stb;
	logic rd_stb;
	logic addr_ok;
	csl_pkg::csl_col_t next_col;
	csl_pkg::csl_pat_t next_pat;
	logic lit;

	assign req = '{paddr: PADDR_IN, psel: PSEL_IN, penable: PENABLE_IN,
		pwrite: PWRITE_IN, pwdata: PWDATA_IN};
	assign wr_stb = req.psel && req.penable && req.pwrite;
	assign rd_stb = req.psel && req.penable && !req.pwrite;
	assign stat_rise = STATUS_IN & ~stat_prev;

	always_comb begin
		case (req.paddr)
			csl_pkg::OFF_STATUS,
			csl_pkg::OFF_IRQ_STAT,
			csl_pkg::OFF_IRQ_MASK,
			csl_pkg::OFF_SLOW_DIV,
			csl_pkg::OFF_FAST_DIV,
			csl_pkg::OFF_LED,
			csl_pkg::OFF_ID: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end

	csl_flash_div u_slow (
		.clk_in(CLOCK_IN),
		.rstn_in(RSTN_IN),
		.half_in(slow_div),
		.wave_out(slow_wave)
	);

	csl_flash_div u_fast (
		.clk_in(CLOCK_IN),
		.rstn_in(RSTN_IN),
		.half_in(fast_div),
		.wave_out(fast_wave)
	);

	csl_flash_div u_act (
		.clk_in(CLOCK_IN),
		.rstn_in(RSTN_IN),
		.half_in(csl_pkg::ACT_DIV),
		.wave_out(act_wave)
	);

	// Priority order: first active condition in this chain wins
	always_comb begin
		next_col = csl_pkg::COL_NONE;
		next_pat = csl_pkg::PAT_OFF;
		if (STATUS_IN[csl_pkg::B_HOT]) begin
			next_col = csl_pkg::COL_RED;
			next_pat = csl_pkg::PAT_FAST;
		end else if (STATUS_IN[csl_pkg::B_INIT_FAIL]) begin
			next_col = csl_pkg::COL_RED;
			next_pat = csl_pkg::PAT_SLOW;
		end else if (STATUS_IN[csl_pkg::B_NOT_INIT]) begin
			next_col = csl_pkg::COL_RED;
			next_pat = csl_pkg::PAT_STEADY;
		end else if (STATUS_IN[csl_pkg::B_LINK_DOWN]) begin
			next_col = csl_pkg::COL_BLUE;
			next_pat = csl_pkg::PAT_FAST;
		end else if (STATUS_IN[csl_pkg::B_IP_WAIT]) begin
			next_col = csl_pkg::COL_BLUE;
			next_pat = csl_pkg::PAT_SLOW;
		end else if (STATUS_IN[csl_pkg::B_FREE_ACQ]) begin
			next_col = csl_pkg::COL_GREEN;
			next_pat = csl_pkg::PAT_FAST;
		end else if (STATUS_IN[csl_pkg::B_TRIG_ACQ]) begin
			next_col = csl_pkg::COL_GREEN;
			next_pat = csl_pkg::PAT_SLOW;
		end else if (STATUS_IN[csl_pkg::B_APP]) begin
			next_col = csl_pkg::COL_GREEN;
			next_pat = csl_pkg::PAT_STEADY;
		end else if (STATUS_IN[csl_pkg::B_IP_OK]) begin
			next_col = csl_pkg::COL_BLUE;
			next_pat = csl_pkg::PAT_STEADY;
		end
	end

	always_comb begin
		case (next_pat)
			csl_pkg::PAT_STEADY: lit = 1'b1;
			csl_pkg::PAT_SLOW: lit = slow_wave;
			csl_pkg::PAT_FAST: lit = fast_wave;
			default: lit = 1'b0;
		endcase
	end

	// Status LED drive, with a software lamp test that lights all colours
	always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			STATUS_LED_OUT <= '0;
		end else if (led_force) begin
			STATUS_LED_OUT <= '{red: 1'b1, green: 1'b1, blue: 1'b1};
		end else begin
			STATUS_LED_OUT.red <= lit && (next_col == csl_pkg::COL_RED);
			STATUS_LED_OUT.green <= lit && (next_col == csl_pkg::COL_GREEN);
			STATUS_LED_OUT.blue <= lit && (next_col == csl_pkg::COL_BLUE);
		end
	end

	// Network LEDs; 1000 Mbit/s takes precedence if both speeds are flagged
	always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			NET_LED_OUT <= '0;
		end else begin
			NET_LED_OUT.speed_1000 <= LINK_1000_IN;
			NET_LED_OUT.speed_100 <= LINK_100_IN && !LINK_1000_IN;
			NET_LED_OUT.activity <= TRAFFIC_IN && act_wave;
		end
	end

	always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			stat_prev <= '0;
		end else begin
			stat_prev <= STATUS_IN;
		end
	end

	// Sticky events; a new rising edge wins over a write-one clear
	always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			irq_stat <= '0;
		end else if (wr_stb && req.paddr == csl_pkg::OFF_IRQ_STAT) begin
			irq_stat <= (irq_stat & ~req.pwdata[csl_pkg::N_STAT-1:0]) | stat_rise;
		end else begin
			irq_stat <= irq_stat | stat_rise;
		end
	end

	always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			IRQ_OUT <= 1'b0;
		end else begin
			IRQ_OUT <= |(irq_stat & irq_mask);
		end
	end

	// Configuration registers
	always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			irq_mask <= '0;
			slow_div <= csl_pkg::SLOW_DIV_RST;
			fast_div <= csl_pkg::FAST_DIV_RST;
			led_force <= 1'b0;
		end else if (wr_stb) begin
			case (req.paddr)
				csl_pkg::OFF_IRQ_MASK: irq_mask <= req.pwdata[csl_pkg::N_STAT-1:0];
				csl_pkg::OFF_SLOW_DIV: slow_div <= req.pwdata;
				csl_pkg::OFF_FAST_DIV: fast_div <= req.pwdata;
				csl_pkg::OFF_LED: led_force <= req.pwdata[0];
				default: led_force <= led_force;
			endcase
		end
	end

	// APB answer: pready comes one cycle after the access phase begins
	always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			PREADY_OUT <= 1'b0;
			PSLVERR_OUT <= 1'b0;
		end else begin
			PREADY_OUT <= req.psel && req.penable && !PREADY_OUT;
			PSLVERR_OUT <= req.psel && req.penable && !PREADY_OUT && !addr_ok;
		end
	end

	always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			PRDATA_OUT <= 32'h0000_0000;
		end else if (rd_stb && !PREADY_OUT) begin
			case (req.paddr)
				csl_pkg::OFF_STATUS: PRDATA_OUT <= 32'(STATUS_IN);
				csl_pkg::OFF_IRQ_STAT: PRDATA_OUT <= 32'(irq_stat);
				csl_pkg::OFF_IRQ_MASK: PRDATA_OUT <= 32'(irq_mask);
				csl_pkg::OFF_SLOW_DIV: PRDATA_OUT <= slow_div;
				csl_pkg::OFF_FAST_DIV: PRDATA_OUT <= fast_div;
				csl_pkg::OFF_LED: PRDATA_OUT <= {26'h000_0000, STATUS_LED_OUT,
					NET_LED_OUT};
				csl_pkg::OFF_ID: PRDATA_OUT <= csl_pkg::ID_VALUE;
				default: PRDATA_OUT <= 32'h0000_0000;
			endcase
		end
	end
endmodule

// ---- common/csl_pkg.sv ----
// Package with register map, field layouts and LED encodings for the camera status LED encoder
package csl_pkg;
	localparam int ADDR_W = 12;
	localparam logic [11:0] OFF_STATUS = 12'h000;
	localparam logic [11:0] OFF_IRQ_STAT = 12'h004;
	localparam logic [11:0] OFF_IRQ_MASK = 12'h008;
	localparam logic [11:0] OFF_SLOW_DIV = 12'h00C;
	localparam logic [11:0] OFF_FAST_DIV = 12'h010;
	localparam logic [11:0] OFF_LED = 12'h014;
	localparam logic [11:0] OFF_ID = 12'h018;
	// Arbitrary neutral identification value
	localparam logic [31:0] ID_VALUE = 32'h0000_0A5C;
	// Half-period counts for the slow, fast and activity flash rates
	localparam int SLOW_HALF_MS = 500;
	localparam int FAST_HALF_MS = 125;
	localparam int CLK_KHZ = 125000;
	localparam logic [31:0] SLOW_DIV_RST = 32'(SLOW_HALF_MS * CLK_KHZ);
	localparam logic [31:0] FAST_DIV_RST = 32'(FAST_HALF_MS * CLK_KHZ);
	localparam int ACT_HALF_MS = 50;
	localparam logic [31:0] ACT_DIV = 32'(ACT_HALF_MS * CLK_KHZ);
	// Status input bit positions
	localparam int B_NOT_INIT = 0;
	localparam int B_INIT_FAIL = 1;
	localparam int B_HOT = 2;
	localparam int B_IP_WAIT = 3;
	localparam int B_LINK_DOWN = 4;
	localparam int B_IP_OK = 5;
	localparam int B_APP = 6;
	localparam int B_TRIG_ACQ = 7;
	localparam int B_FREE_ACQ = 8;
	localparam int N_STAT = 9;
	typedef enum logic [1:0] {PAT_STEADY, PAT_SLOW, PAT_FAST, PAT_OFF} csl_pat_t;
	typedef enum logic [1:0] {COL_NONE, COL_RED, COL_BLUE, COL_GREEN} csl_col_t;
	typedef struct packed {
		logic red;
		logic green;
		logic blue;
	} csl_rgb_t;
	typedef struct packed {
		logic speed_1000;
		logic speed_100;
		logic activity;
	} csl_net_t;
	typedef struct packed {
		logic [ADDR_W-1:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} csl_apb_req_t;
endpackage

// ---- rtl/csl_flash_div.sv ----
// Free-running divider producing a square wave with a programmable half period
`timescale 1ns/10ps
module csl_flash_div (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic [31:0] half_in,
	output logic wave_out
);
	logic [31:0] count;

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			count <= 32'h0000_0000;
			wave_out <= 1'b0;
		end else if (count + 32'h0000_0001 >= half_in) begin
			count <= 32'h0000_0000;
			wave_out <= ~wave_out;
		end else begin
			count <= count + 32'h0000_0001;
		end
	end
endmodule

// ---- sim/csl_top_monitor.sv ----
// Checker of lamp encoding and APB answer timing
`timescale 1ns/10ps
module csl_top_monitor (
	input wire logic CLOCK_IN,
	input wire logic RSTN_IN,
	input wire logic [csl_pkg::N_STAT-1:0] STATUS_IN,
	input wire logic LINK_100_IN,
	input wire logic LINK_1000_IN,
	input wire logic TRAFFIC_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PREADY_OUT,
	input wire csl_pkg::csl_rgb_t STATUS_LED_OUT,
	input wire csl_pkg::csl_net_t NET_LED_OUT
);
	default clocking cb @(posedge CLOCK_IN);
	endclocking
	default disable iff (!RSTN_IN);
	chk_hot_red: assert property (STATUS_IN[2] |=> STATUS_LED_OUT[1:0] == 2'h0)
		else $error("hot lamp not red");
	chk_uninit_red: assert property (STATUS_IN == 9'h001 |=> STATUS_LED_OUT == 3'h4)
		else $error("uninit lamp not steady red");
	chk_ipok_blue: assert property (STATUS_IN == 9'h020 |=> STATUS_LED_OUT == 3'h1)
		else $error("ip lamp not steady blue");
	chk_app_green: assert property (STATUS_IN[8:6] == 3'h1 && STATUS_IN[4:0] == 5'h00
		|=> STATUS_LED_OUT == 3'h2) else $error("app lamp not steady green");
	chk_speed_orange: assert property (LINK_1000_IN |=> NET_LED_OUT[2:1] == 2'h2)
		else $error("fast link not orange");
	chk_speed_green: assert property (LINK_100_IN && !LINK_1000_IN |=> NET_LED_OUT[2:1] == 2'h1)
		else $error("slow link not green");
	chk_idle_dark: assert property (!TRAFFIC_IN |=> !NET_LED_OUT.activity)
		else $error("activity lit without traffic");
	chk_ready_pulse: assert property (PSEL_IN && PENABLE_IN && !PREADY_OUT
		|=> PREADY_OUT ##1 !PREADY_OUT) else $error("ready not one pulse");
endmodule
bind csl_top csl_top_monitor csl_top_monitor_i (.CLOCK_IN, .RSTN_IN, .STATUS_IN, .LINK_100_IN,
	.LINK_1000_IN, .TRAFFIC_IN, .PSEL_IN, .PENABLE_IN, .PREADY_OUT, .STATUS_LED_OUT,
	.NET_LED_OUT);

// ---- sim/csl_observer.sv ----
// Observer that watches the status lamp for 64 cycles and names colour and pattern
`timescale 1ns/10ps
module csl_observer (
	input wire logic clk_in,
	input wire csl_pkg::csl_rgb_t led_in,
	input wire logic start_in,
	output logic done_out,
	output logic [4:0] view_out
);
	logic [6:0] n = 7'h40;
	logic [6:0] flips;
	logic [2:0] lit;
	logic [2:0] prev;
	csl_pkg::csl_pat_t pat;
	always_ff @(posedge clk_in) begin
		done_out <= 1'b0;
		prev <= led_in;
		if (start_in) begin
			n <= 7'h00;
			lit <= 3'h0;
			flips <= 7'h00;
		end else if (n < 7'h40) begin
			n <= n + 7'h01;
			lit <= lit | led_in;
			flips <= flips + 7'(led_in != prev);
			done_out <= (n == 7'h3F);
		end
	end
	// Between 1 and 15 changes in the window reads as a slow blink
	assign pat = (lit == 3'h0) ? csl_pkg::PAT_OFF : (flips == 7'h00) ? csl_pkg::PAT_STEADY
		: (flips < 7'h10) ? csl_pkg::PAT_SLOW : csl_pkg::PAT_FAST;
	assign view_out = {pat, lit};
endmodule

// ---- sim/csl_top_bench.sv ----
// Self-checking bench for the status lamp encoder
`timescale 1ns/10ps
module csl_top_bench;
	logic clk = 1'b0, rstn = 1'b0, l100 = 1'b0, l1000 = 1'b0, traf = 1'b0, start = 1'b0;
	logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, pready, pslverr, irq, done;
	logic [8:0] stat = 9'h000;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [4:0] view;
	csl_pkg::csl_rgb_t led;
	csl_pkg::csl_net_t net;
	logic [32:0] q[$];
	int err_total = 0, compares = 0;
	always #4 clk = ~clk;
	csl_top csl_top_i (.CLOCK_IN(clk), .RSTN_IN(rstn), .STATUS_IN(stat), .LINK_100_IN(l100),
		.LINK_1000_IN(l1000), .TRAFFIC_IN(traf), .PADDR_IN(paddr), .PSEL_IN(psel),
		.PENABLE_IN(pen), .PWRITE_IN(pwr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
		.PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .STATUS_LED_OUT(led),
		.NET_LED_OUT(net), .IRQ_OUT(irq));
	csl_observer csl_observer_i (.clk_in(clk), .led_in(led), .start_in(start),
		.done_out(done), .view_out(view));
	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [32:0] e);
		int n;
		@(posedge clk);
		{psel, pen, pwr, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		if (!w) q.push_back(e);
		@(posedge clk);
		pen <= 1'b1;
		n = 0;
		@(posedge clk);
		while (pready !== 1'b1 && n < 20) begin
			n++;
			@(posedge clk);
		end
		if (n == 20) err_total++;
		{psel, pen} <= 2'h0;
	endtask
	function automatic logic [32:0] want(input logic [8:0] s);
		logic [4:0] pv [9] = '{5'h04, 5'h0C, 5'h14, 5'h09, 5'h11, 5'h01, 5'h02, 5'h0A, 5'h12};
		int ord [9] = '{5, 6, 7, 8, 3, 4, 0, 1, 2};
		logic [4:0] v;
		v = 5'h18;
		foreach (ord[k]) if (s[ord[k]]) v = pv[ord[k]];
		return {28'h0, v};
	endfunction
	always @(posedge clk) begin
		if (psel && pen && pready === 1'b1 && !pwr) check({pslverr, prdata}, q.pop_front());
		if (done === 1'b1) check({28'h0, view}, q.pop_front());
	end
	initial begin
		#200000;
		err_total++;
		test_done();
	end
	initial begin
		int n;
		logic [8:0] s;
		void'($urandom(20057));
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		apb(1'b0, csl_pkg::OFF_SLOW_DIV, 32'h0, {1'b0, csl_pkg::SLOW_DIV_RST});
		apb(1'b0, 12'h0FC, 32'h0, 33'h1_0000_0000);
		apb(1'b1, csl_pkg::OFF_SLOW_DIV, 32'h0000_0008, 33'h0);
		apb(1'b1, csl_pkg::OFF_FAST_DIV, 32'h0000_0002, 33'h0);
		apb(1'b0, csl_pkg::OFF_FAST_DIV, 32'h0, 33'h0_0000_0002);
		$display("register test done");
		for (int i = 0; i < 16; i++) begin
			s = (i < 9) ? 9'h001 << i : (i == 9) ? 9'h000 : 9'($urandom);
			@(posedge clk);
			stat <= s;
			{l1000, l100, traf} <= 3'($urandom);
			repeat (2) @(posedge clk);
			check({30'h0, net}, {30'h0, l1000, l100 && !l1000, 1'b0});
			start <= 1'b1;
			q.push_back(want(s));
			@(posedge clk);
			start <= 1'b0;
			n = 0;
			while (done !== 1'b1 && n < 200) begin
				n++;
				@(posedge clk);
			end
		end
		$display("lamp test done");
		stat <= 9'h000;
		apb(1'b1, csl_pkg::OFF_IRQ_STAT, 32'h0000_01FF, 33'h0);
		stat <= 9'h001;
		apb(1'b0, csl_pkg::OFF_IRQ_STAT, 32'h0, 33'h0_0000_0001);
		check({32'h0, irq}, 33'h0);
		apb(1'b1, csl_pkg::OFF_IRQ_MASK, 32'h0000_0001, 33'h0);
		repeat (2) @(posedge clk);
		check({32'h0, irq}, 33'h1);
		apb(1'b1, csl_pkg::OFF_IRQ_STAT, 32'h0000_0001, 33'h0);
		repeat (2) @(posedge clk);
		check({32'h0, irq}, 33'h0);
		$display("interrupt test done");
		apb(1'b0, csl_pkg::OFF_STATUS, 32'h0, 33'h0_0000_0001);
		stat <= 9'h000;
		{l1000, l100, traf} <= 3'h0;
		apb(1'b0, csl_pkg::OFF_ID, 32'h0, {1'b0, csl_pkg::ID_VALUE});
		apb(1'b1, csl_pkg::OFF_LED, 32'h0000_0001, 33'h0);
		apb(1'b0, csl_pkg::OFF_LED, 32'h0, 33'h0_0000_0038);
		check({30'h0, led}, 33'h0_0000_0007);
		apb(1'b1, csl_pkg::OFF_LED, 32'h0000_0000, 33'h0);
		repeat (2) @(posedge clk);
		check({30'h0, led}, 33'h0_0000_0000);
		$display("lamp test register done");
		test_done();
	end
endmodule
